//--- logic/cprb_pkg.sv
// Purpose : shared constants and types of the channel parameter bank
// Assumes : one 16-bit word per register index, 64 indices per channel
// Notes   : indices are register numbers, not byte addresses
package cprb_pkg;

   // ----------------------------------------------------------------
   // geometry
   // ----------------------------------------------------------------
   localparam int unsigned REG_COUNT = 64;
   localparam int unsigned IDX_W     = 6;
   localparam int unsigned WORD_W    = 16;

   // ----------------------------------------------------------------
   // register indices
   // ----------------------------------------------------------------
   localparam logic [5:0] IDX_RAW_CONV   = 6'h00;
   localparam logic [5:0] IDX_RAW_LEAD   = 6'h01;
   localparam logic [5:0] IDX_DIAG       = 6'h06;
   localparam logic [5:0] IDX_FUNC       = 6'h07;
   localparam logic [5:0] IDX_UNIT_TYPE  = 6'h08;
   localparam logic [5:0] IDX_FW_REV     = 6'h09;
   localparam logic [5:0] IDX_CHAIN_LEN  = 6'h0A;
   localparam logic [5:0] IDX_CHAN_CNT   = 6'h0B;
   localparam logic [5:0] IDX_MIN_LEN    = 6'h0C;
   localparam logic [5:0] IDX_LAYOUT     = 6'h0D;
   localparam logic [5:0] IDX_ALIGN      = 6'h0F;
   localparam logic [5:0] IDX_HW_OFF     = 6'h11;
   localparam logic [5:0] IDX_HW_GAIN    = 6'h12;
   localparam logic [5:0] IDX_SC_OFF     = 6'h13;
   localparam logic [5:0] IDX_SC_GAIN    = 6'h14;
   localparam logic [5:0] IDX_TWO_WIRE   = 6'h15;
   localparam logic [5:0] IDX_KEY        = 6'h1F;
   localparam logic [5:0] IDX_FEAT       = 6'h20;

   // region bounds
   localparam logic [5:0] PROC_LAST      = 6'h07;
   localparam logic [5:0] TYPE_LAST      = 6'h0F;
   localparam logic [5:0] MFG_FIRST      = 6'h10;
   localparam logic [5:0] MFG_LAST       = 6'h1E;
   localparam logic [5:0] USER_LAST      = 6'h2F;
   localparam logic [5:0] EXT_LAST       = 6'h3F;

   // ----------------------------------------------------------------
   // values and fields
   // ----------------------------------------------------------------
   localparam logic [15:0] UNLOCK_CODE    = 16'h1235;
   localparam logic [15:0] ZERO_WORD      = 16'h0000;
   localparam logic [15:0] SC_OFF_RST     = 16'h0000;
   localparam logic [15:0] SC_GAIN_RST    = 16'h00A0;
   localparam logic [15:0] FEAT_RST       = 16'h0106;
   localparam logic [7:0]  FUNC_RESULT    = 8'h00;
   localparam int unsigned FEAT_SCALE_BIT = 1;
   localparam int unsigned SC_GAIN_SHIFT  = 8;
   localparam int unsigned MIN_LEN_OPT_BIT = 7;
   localparam int unsigned LAYOUT_VAR_BIT = 4;
   localparam logic [7:0]  LAYOUT_NONE    = 8'h00;
   localparam logic [7:0]  LAYOUT_BYTES   = 8'h01;
   localparam logic [7:0]  LAYOUT_WORDS   = 8'h03;
   localparam logic [7:0]  LAYOUT_DWORDS  = 8'h05;
   localparam logic [7:0]  LAYOUT_FIXED_LAST = 8'h08;
   localparam logic [7:0]  LAYOUT_VAR_FIRST  = 8'h11;
   localparam logic [7:0]  LAYOUT_VAR_LAST   = 8'h16;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_INIT = 2'b00,
      ST_IDLE = 2'b01,
      ST_WAIT = 2'b11,
      ST_DONE = 2'b10
   } cprb_state_e;

   typedef struct packed {
      logic [15:0] raw_conv;
      logic [15:0] raw_lead;
      logic [7:0]  status;
   } cprb_proc_s;

   typedef struct packed {
      logic [15:0] hw_offset;
      logic [15:0] hw_gain;
      logic [15:0] scale_offset;
      logic [15:0] scale_gain;
      logic [15:0] two_wire;
      logic [15:0] features;
   } cprb_coef_s;

   typedef struct packed {
      logic        wr;
      logic [5:0]  idx;
      logic [15:0] wdata;
   } cprb_req_s;

   // legal data layout codes, fixed or variable channel length
   function automatic logic layout_ok(input logic [7:0] code);
      layout_ok = (code <= LAYOUT_FIXED_LAST) ||
                  (code >= LAYOUT_VAR_FIRST && code <= LAYOUT_VAR_LAST);
   endfunction : layout_ok

endpackage : cprb_pkg

//--- logic/cprb_nv_store.sv
// Purpose : word store standing for the serial nonvolatile parameter image
// Assumes : one read per enabled cycle, plus one write when we is set
// Notes   : no reset on the array, contents outlive a reset
`timescale 1ns/1ps
module cprb_nv_store #(
   parameter int unsigned AW = 8,
   parameter int unsigned DW = 16
) (
   input  wire logic          sys_clk,
   input  wire logic          ce,
   input  wire logic          we,
   input  wire logic [AW-1:0] addr,
   input  wire logic [DW-1:0] wdata,
   output logic      [DW-1:0] rdata_q
);

   logic [DW-1:0] mem [0:(1<<AW)-1];

   // ----------------------------------------------------------------
   // registered read, write-first is not needed by the bank
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (ce) begin
         if (we) begin
            mem[addr] <= wdata;
         end
         rdata_q <= mem[addr];
      end
   end

endmodule : cprb_nv_store

//--- logic/cprb_bank.sv
// Purpose : per-channel bank of 64 word registers with code-word lock
// Assumes : requests come from logic on sys_clk, one at a time
// Notes   : answer two cycles after a request is taken
`timescale 1ns/1ps
module cprb_bank #(
   parameter int unsigned CHANNELS   = 4,
   parameter logic [15:0] UNIT_TYPE  = 16'h0ABC, // arbitrary value
   parameter logic [15:0] FW_REV     = 16'h3141, // ascii, arbitrary value
   parameter logic [15:0] CHAIN_LEN  = 16'h0218,
   parameter logic [15:0] CHAN_CNT   = 16'h0218,
   parameter logic [15:0] MIN_LEN    = 16'h0098,
   parameter logic [15:0] LAYOUT     = 16'h0000,
   parameter int unsigned CHW        = (CHANNELS > 1) ? $clog2(CHANNELS) : 1
) (
   input  wire logic                 sys_clk,
   input  wire logic                 resetn,
   input  wire logic                 ce,
   input  wire logic                 nv_format,
   input  wire logic                 req_valid,
   input  wire logic [CHW-1:0]       req_chan,
   input  wire cprb_pkg::cprb_req_s  req,
   input  wire cprb_pkg::cprb_proc_s proc_in [CHANNELS],
   output logic                      req_ready_q,
   output logic                      ack_q,
   output logic [15:0]               rdata_q,
   output logic                      init_done_q,
   output logic                      status_optional_q,
   output cprb_pkg::cprb_coef_s      coef_q   [CHANNELS],
   output logic [15:0]               scaled_q [CHANNELS]
);

   localparam int unsigned AW = CHW + cprb_pkg::IDX_W;
   localparam logic [AW-1:0] ADDR_LAST = AW'(CHANNELS * 64 - 1);

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   if (CHANNELS < 1 || CHANNELS > 64) begin : g_bad_chan
      $error("cprb_bank: CHANNELS must be 1 to 64");
   end
   if (!cprb_pkg::layout_ok(LAYOUT[7:0]) || LAYOUT[15:8] != 8'h00) begin
      : g_bad_layout
      $error("cprb_bank: LAYOUT is not a legal layout code");
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // factory default of a stored word
   function automatic logic [15:0] nv_default(input logic [5:0] idx);
      case (idx)
         cprb_pkg::IDX_SC_OFF:  nv_default = cprb_pkg::SC_OFF_RST;
         cprb_pkg::IDX_SC_GAIN: nv_default = cprb_pkg::SC_GAIN_RST;
         cprb_pkg::IDX_FEAT:    nv_default = cprb_pkg::FEAT_RST;
         default:               nv_default = cprb_pkg::ZERO_WORD;
      endcase
   endfunction : nv_default

   // stored words live above the type area, except the key word
   function automatic logic is_stored(input logic [5:0] idx);
      is_stored = (idx >= cprb_pkg::MFG_FIRST) &&
                  (idx != cprb_pkg::IDX_KEY);
   endfunction : is_stored

   // update the working copy of one coefficient word
   function automatic cprb_pkg::cprb_coef_s coef_put(
      input cprb_pkg::cprb_coef_s c,
      input logic [5:0]           idx,
      input logic [15:0]          v);
      coef_put = c;
      case (idx)
         cprb_pkg::IDX_HW_OFF:   coef_put.hw_offset    = v;
         cprb_pkg::IDX_HW_GAIN:  coef_put.hw_gain      = v;
         cprb_pkg::IDX_SC_OFF:   coef_put.scale_offset = v;
         cprb_pkg::IDX_SC_GAIN:  coef_put.scale_gain   = v;
         cprb_pkg::IDX_TWO_WIRE: coef_put.two_wire     = v;
         cprb_pkg::IDX_FEAT:     coef_put.features     = v;
         default:                coef_put = c;
      endcase
   endfunction : coef_put

   // factory straight line: raw * gain / 256 + offset, saturated
   function automatic logic [15:0] scale(
      input logic [15:0] raw,
      input logic [15:0] gain,
      input logic [15:0] off);
      logic signed [31:0] prod;
      logic signed [31:0] sum;
      prod = 32'($signed(raw) * $signed(gain));
      sum  = (prod >>> cprb_pkg::SC_GAIN_SHIFT) + 32'($signed(off));
      if (sum > 32'sd32767) begin
         scale = 16'h7FFF;
      end else if (sum < -32'sd32768) begin
         scale = 16'h8000;
      end else begin
         scale = sum[15:0];
      end
   endfunction : scale

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   cprb_pkg::cprb_state_e state_q;
   cprb_pkg::cprb_state_e state_d;
   logic [AW-1:0]         init_cnt_q;
   logic                  init_cap_q;
   logic [AW-1:0]         init_cap_addr_q;
   logic                  fmt_meta_q;
   logic                  fmt_sync_q;
   logic [CHW-1:0]        chan_q;
   cprb_pkg::cprb_req_s   req_q;
   logic [CHANNELS-1:0]   unlock_q;
   logic [7:0]            func_num_q [CHANNELS];
   logic [15:0]           align_q    [CHANNELS];
   logic                  take;
   logic                  host_we;
   logic                  mem_we;
   logic [AW-1:0]         mem_addr;
   logic [15:0]           mem_wdata;
   logic [15:0]           mem_rdata;
   logic [15:0]           rd_word;

   // format strap crosses in from a pin
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         fmt_meta_q <= 1'b0;
         fmt_sync_q <= 1'b0;
      end else if (ce) begin
         fmt_meta_q <= nv_format;
         fmt_sync_q <= fmt_meta_q;
      end
   end

   assign take = (state_q == cprb_pkg::ST_IDLE) && req_valid;

   // locked areas and read-only words swallow writes silently
   assign host_we = take && req.wr && is_stored(req.idx) &&
                    unlock_q[req_chan];

   // ----------------------------------------------------------------
   // store port: init walk or host write
   // ----------------------------------------------------------------
   always_comb begin
      if (state_q == cprb_pkg::ST_INIT) begin
         mem_we    = fmt_sync_q;
         mem_addr  = init_cnt_q;
         mem_wdata = nv_default(init_cnt_q[5:0]);
      end else begin
         mem_we    = host_we;
         mem_addr  = {req_chan, req.idx};
         mem_wdata = req.wdata;
      end
   end

   cprb_nv_store #(
      .AW (AW),
      .DW (cprb_pkg::WORD_W)
   ) u_store (
      .sys_clk (sys_clk),
      .ce      (ce),
      .we      (mem_we),
      .addr    (mem_addr),
      .wdata   (mem_wdata),
      .rdata_q (mem_rdata)
   );

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      case (state_q)
         cprb_pkg::ST_INIT: begin
            if (init_cnt_q == ADDR_LAST) begin
               state_d = cprb_pkg::ST_IDLE;
            end
         end
         cprb_pkg::ST_IDLE: begin
            if (req_valid) begin
               state_d = cprb_pkg::ST_WAIT;
            end
         end
         cprb_pkg::ST_WAIT: state_d = cprb_pkg::ST_DONE;
         cprb_pkg::ST_DONE: state_d = cprb_pkg::ST_IDLE;
         default:           state_d = cprb_pkg::ST_INIT;
      endcase
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_q     <= cprb_pkg::ST_INIT;
         req_ready_q <= 1'b0;
         init_done_q <= 1'b0;
      end else if (ce) begin
         state_q     <= state_d;
         req_ready_q <= (state_d == cprb_pkg::ST_IDLE);
         init_done_q <= (state_d != cprb_pkg::ST_INIT);
      end
   end

   // init walk over every stored word, one per cycle
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         init_cnt_q      <= '0;
         init_cap_q      <= 1'b0;
         init_cap_addr_q <= '0;
      end else if (ce) begin
         init_cap_q      <= (state_q == cprb_pkg::ST_INIT);
         init_cap_addr_q <= init_cnt_q;
         if (state_q == cprb_pkg::ST_INIT && init_cnt_q != ADDR_LAST) begin
            init_cnt_q <= init_cnt_q + 1'b1;
         end
      end
   end

   // request capture for the read answer
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         chan_q <= '0;
         req_q  <= '0;
      end else if (ce && take) begin
         chan_q <= req_chan;
         req_q  <= req;
      end
   end

   // ----------------------------------------------------------------
   // ram words: key lock, function number, alignment
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         unlock_q <= '0;
         for (int c = 0; c < CHANNELS; c++) begin
            func_num_q[c] <= 8'h00;
            align_q[c]    <= 16'h0000;
         end
      end else if (ce && take && req.wr) begin
         if (req.idx == cprb_pkg::IDX_KEY) begin
            // only the exact code opens, anything else closes
            unlock_q[req_chan] <=
               (req.wdata == cprb_pkg::UNLOCK_CODE);
         end
         if (req.idx == cprb_pkg::IDX_FUNC) begin
            func_num_q[req_chan] <= req.wdata[7:0];
         end
         if (req.idx == cprb_pkg::IDX_ALIGN) begin
            align_q[req_chan] <= req.wdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // working copy of coefficients, loaded at init and on writes
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         for (int c = 0; c < CHANNELS; c++) begin
            coef_q[c]          <= '0;
            coef_q[c].scale_gain <= cprb_pkg::SC_GAIN_RST;
            coef_q[c].features <= cprb_pkg::FEAT_RST;
         end
      end else if (ce) begin
         if (init_cap_q) begin
            coef_q[init_cap_addr_q[AW-1:6]] <= coef_put(
               coef_q[init_cap_addr_q[AW-1:6]], init_cap_addr_q[5:0],
               fmt_sync_q ? nv_default(init_cap_addr_q[5:0])
                          : mem_rdata);
         end
         // the last init capture overlaps the first idle cycle, so a
         // host write taken there must not be lost behind it
         if (host_we) begin
            coef_q[req_chan] <= coef_put(coef_q[req_chan], req.idx,
                                         req.wdata);
         end
      end
   end

   // ----------------------------------------------------------------
   // measured value path per channel
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         for (int c = 0; c < CHANNELS; c++) begin
            scaled_q[c] <= 16'h0000;
         end
      end else if (ce) begin
         for (int c = 0; c < CHANNELS; c++) begin
            if (coef_q[c].features[cprb_pkg::FEAT_SCALE_BIT]) begin
               scaled_q[c] <= scale(proc_in[c].raw_conv,
                                    coef_q[c].scale_gain,
                                    coef_q[c].scale_offset);
            end else begin
               scaled_q[c] <= proc_in[c].raw_conv;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // read mux, evaluated in the wait cycle
   // ----------------------------------------------------------------
   always_comb begin
      rd_word = cprb_pkg::ZERO_WORD;
      case (req_q.idx)
         cprb_pkg::IDX_RAW_CONV:  rd_word = proc_in[chan_q].raw_conv;
         cprb_pkg::IDX_RAW_LEAD:  rd_word = proc_in[chan_q].raw_lead;
         cprb_pkg::IDX_DIAG:
            rd_word = {8'h00, proc_in[chan_q].status};
         cprb_pkg::IDX_FUNC:
            rd_word = {cprb_pkg::FUNC_RESULT, func_num_q[chan_q]};
         cprb_pkg::IDX_UNIT_TYPE: rd_word = UNIT_TYPE;
         cprb_pkg::IDX_FW_REV:    rd_word = FW_REV;
         cprb_pkg::IDX_CHAIN_LEN: rd_word = CHAIN_LEN;
         cprb_pkg::IDX_CHAN_CNT:  rd_word = CHAN_CNT;
         cprb_pkg::IDX_MIN_LEN:   rd_word = MIN_LEN;
         cprb_pkg::IDX_LAYOUT:    rd_word = LAYOUT;
         cprb_pkg::IDX_ALIGN:     rd_word = align_q[chan_q];
         cprb_pkg::IDX_KEY: begin
            rd_word = unlock_q[chan_q] ? cprb_pkg::UNLOCK_CODE
                                       : cprb_pkg::ZERO_WORD;
         end
         default: begin
            // reserved process and type words read zero
            if (is_stored(req_q.idx)) begin
               rd_word = mem_rdata;
            end
         end
      endcase
   end

   // answer registers, write acks carry zero data
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ack_q   <= 1'b0;
         rdata_q <= 16'h0000;
      end else if (ce) begin
         ack_q <= (state_q == cprb_pkg::ST_WAIT);
         if (state_q == cprb_pkg::ST_WAIT) begin
            rdata_q <= req_q.wr ? cprb_pkg::ZERO_WORD : rd_word;
         end
      end
   end

   // optional status byte flag from the length byte msb
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         status_optional_q <= 1'b0;
      end else if (ce) begin
         status_optional_q <= MIN_LEN[cprb_pkg::MIN_LEN_OPT_BIT];
      end
   end

endmodule : cprb_bank

//--- bench/cprb_bank_assertions.sv
// Purpose : port-level checks of the channel parameter bank
// Assumes : ce is held high by the bench
// Notes   : lock state is mirrored per channel from taken key writes
`timescale 1ns/1ps
module cprb_bank_assertions #(
   parameter int unsigned CHW = 2
) (
   input wire logic                sys_clk,
   input wire logic                resetn,
   input wire logic                ce,
   input wire logic                req_valid,
   input wire logic [CHW-1:0]      req_chan,
   input wire cprb_pkg::cprb_req_s req,
   input wire logic                req_ready_q,
   input wire logic                ack_q,
   input wire logic [15:0]         rdata_q,
   input wire logic                init_done_q,
   input wire logic                status_optional_q
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   logic            take;
   logic            wr_take;
   logic            key_rd;
   logic            diag_rd;
   logic [2**CHW-1:0] open_q;
   // decoded events of the register port
   assign take    = req_valid && req_ready_q && ce;
   assign wr_take = take && req.wr;
   assign key_rd  = take && !req.wr && req.idx == cprb_pkg::IDX_KEY;
   assign diag_rd = take && !req.wr && req.idx == cprb_pkg::IDX_DIAG;
   // lock mirror; a reset closes every channel
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) open_q <= '0;
      else if (wr_take && req.idx == cprb_pkg::IDX_KEY)
         open_q[req_chan] <= (req.wdata == cprb_pkg::UNLOCK_CODE);
   end
   a_ack_two_after: assert property (take ##1 ce |-> ##1 ack_q)
      else $error("answer not two cycles after take");
   a_ack_one_pulse: assert property (ack_q |=> !ack_q)
      else $error("answer longer than one cycle");
   a_ack_has_cause: assert property (ack_q |-> $past(take, 2))
      else $error("answer without a request");
   a_busy_window: assert property (take |=> (!req_ready_q)[*2] ##1
      req_ready_q) else $error("ready window wrong");
   a_ready_after_init: assert property (req_ready_q |-> init_done_q)
      else $error("ready before init walk");
   a_write_zero_data: assert property (ack_q && $past(wr_take, 2)
      |-> rdata_q == 16'h0000) else $error("write answer not zero");
   a_key_readback: assert property (ack_q && $past(key_rd, 2)
      |-> rdata_q == (open_q[$past(req_chan, 2)] ? cprb_pkg::UNLOCK_CODE
      : 16'h0000)) else $error("key readback wrong");
   a_diag_high_zero: assert property (ack_q && $past(diag_rd, 2)
      |-> rdata_q[15:8] == 8'h00) else $error("status high byte");
   a_status_optional: assert property (
      init_done_q |-> status_optional_q)
      else $error("status optional flag low");
   c_write: cover property (wr_take);
   c_key_read: cover property (key_rd);
   c_open_answer: cover property (ack_q && open_q != '0);
endmodule : cprb_bank_assertions
bind cprb_bank cprb_bank_assertions #(.CHW(CHW)) cprb_bank_assertions_i (
   .sys_clk(sys_clk), .resetn(resetn), .ce(ce), .req_valid(req_valid),
   .req_chan(req_chan), .req(req), .req_ready_q(req_ready_q),
   .ack_q(ack_q), .rdata_q(rdata_q), .init_done_q(init_done_q),
   .status_optional_q(status_optional_q));

//--- bench/cprb_coupler.sv
// Purpose : coupler model issuing register accesses to the bank
// Assumes : called just after a rising edge of sys_clk
// Notes   : the released request word carries the inverse of the last value, req_chan holds
`timescale 1ns/1ps
module cprb_coupler #(
   parameter int unsigned CHW = 2
) (
   input  wire logic           sys_clk,
   input  wire logic           req_ready_q,
   input  wire logic           ack_q,
   input  wire logic [15:0]    rdata_q,
   output logic                req_valid,
   output logic [CHW-1:0]      req_chan,
   output cprb_pkg::cprb_req_s req
);
   initial begin
      req_valid = 1'b0;
      req_chan  = '0;
      req       = '0;
   end
   // hold the request until taken, then wait a bounded time for answer
   task automatic xfer(input logic wr, input logic [CHW-1:0] ch,
         input logic [5:0] idx, input logic [15:0] wd,
         output logic [15:0] rd);
      int   n;
      logic got;
      rd  = 16'hFFFF;
      got = 1'b0;
      req_valid <= 1'b1;
      req_chan  <= ch;
      req       <= {wr, idx, wd};
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (!req_ready_q && n < 400);
      req_valid <= 1'b0;
      req       <= ~{wr, idx, wd};
      for (n = 0; n < 8 && !got; n++) begin
         @(posedge sys_clk);
         got = ack_q;
         if (ack_q) rd = rdata_q;
      end
      if (!got) rd = 16'hDEAD; // no answer: force a mismatch
   endtask : xfer
endmodule : cprb_coupler

//--- bench/testbench.sv
// Purpose : self-checking bench of the channel parameter bank
// Assumes : four channels, default type words
// Notes   : second reset proves the parameter store keeps its words
`timescale 1ns/1ps
module testbench;
   logic                 sys_clk, resetn, ce, nv_format, req_valid;
   logic                 req_ready_q, ack_q, init_done_q, status_optional_q;
   logic [1:0]           req_chan;
   logic [15:0]          rdata_q, rd;
   cprb_pkg::cprb_req_s  req;
   cprb_pkg::cprb_proc_s proc_in [4];
   cprb_pkg::cprb_coef_s coef_q [4];
   logic [15:0]          scaled_q [4];
   int                   num_errors, comparisons, cycles, i;
   logic [5:0]  ix [7] = '{6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h21, 6'h3F};
   logic [15:0] dv [7] = '{16'hED12, 16'h2734, 16'h0010, 16'h0100,
                           16'h01A5, 16'h7777, 16'h3F3F};
   cprb_bank cprb_bank_i (.sys_clk(sys_clk), .resetn(resetn), .ce(ce),
      .nv_format(nv_format), .req_valid(req_valid), .req_chan(req_chan),
      .req(req), .proc_in(proc_in), .req_ready_q(req_ready_q),
      .ack_q(ack_q), .rdata_q(rdata_q), .init_done_q(init_done_q),
      .status_optional_q(status_optional_q), .coef_q(coef_q),
      .scaled_q(scaled_q));
   cprb_coupler cprb_coupler_i (.sys_clk(sys_clk), .req_ready_q(req_ready_q),
      .ack_q(ack_q), .rdata_q(rdata_q), .req_valid(req_valid),
      .req_chan(req_chan), .req(req));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic rdc(input logic [1:0] ch, input logic [5:0] idx,
         input logic [15:0] exp);
      cprb_coupler_i.xfer(1'b0, ch, idx, 16'h0000, rd);
      chk(rd, exp);
   endtask : rdc
   task automatic wr(input logic [1:0] ch, input logic [5:0] idx,
         input logic [15:0] d);
      cprb_coupler_i.xfer(1'b1, ch, idx, d, rd);
      chk(rd, 16'h0000);
   endtask : wr
   // reset, then wait for the init walk; the strap is set before release
   task automatic boot(input logic nvf);
      resetn    <= 1'b0;
      nv_format <= nvf;
      repeat (12) @(posedge sys_clk);
      resetn <= 1'b1;
      while (!init_done_q) @(posedge sys_clk);
   endtask : boot
   task automatic conclude;
      if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : conclude
   // hang guard: whole run needs about 700 cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 4000) begin
         num_errors++;
         conclude();
      end
   end
   initial begin
      resetn = 1'b0;
      ce = 1'b1;
      nv_format = 1'b1;
      for (i = 0; i < 4; i++)
         proc_in[i] = {16'(256 * (i + 1)), 16'(16'h01A0 + i), 8'(8'h40 + i)};
      boot(1'b1);
      chk({15'h0000, status_optional_q}, 16'h0001);
      rdc(0, 6'h08, 16'h0ABC);
      rdc(0, 6'h09, 16'h3141);
      rdc(0, 6'h0A, 16'h0218);
      rdc(0, 6'h0B, 16'h0218);
      rdc(0, 6'h0C, 16'h0098);
      rdc(0, 6'h0D, 16'h0000);
      wr(0, 6'h08, 16'h5555);
      rdc(0, 6'h08, 16'h0ABC);
      rdc(1, 6'h00, 16'h0200);
      rdc(1, 6'h01, 16'h01A1);
      rdc(1, 6'h06, 16'h0041);
      rdc(2, 6'h00, 16'h0300);
      rdc(1, 6'h13, 16'h0000);
      rdc(1, 6'h14, 16'h00A0);
      rdc(1, 6'h20, 16'h0106);
      rdc(1, 6'h1F, 16'h0000);
      wr(1, 6'h14, 16'h0100);
      rdc(1, 6'h14, 16'h00A0);
      wr(1, 6'h21, 16'h7777);
      rdc(1, 6'h21, 16'h0000);
      wr(1, 6'h1F, 16'h1235);
      rdc(1, 6'h1F, 16'h1235);
      rdc(0, 6'h1F, 16'h0000);
      for (i = 0; i < 7; i++) wr(1, ix[i], dv[i]);
      for (i = 0; i < 7; i++) rdc(1, ix[i], dv[i]);
      wr(1, 6'h07, 16'hAB05);
      rdc(1, 6'h07, 16'h0005);
      repeat (4) @(posedge sys_clk);
      chk(coef_q[1].scale_gain, 16'h0100);
      chk(scaled_q[1], 16'h0210);
      chk(scaled_q[0], 16'h00A0);
      wr(1, 6'h1F, 16'h1236);
      rdc(1, 6'h1F, 16'h0000);
      wr(1, 6'h14, 16'h0200);
      rdc(1, 6'h14, 16'h0100);
      boot(1'b0);
      chk(coef_q[1].hw_offset, 16'hED12);
      rdc(1, 6'h14, 16'h0100);
      rdc(1, 6'h3F, 16'h3F3F);
      rdc(1, 6'h1F, 16'h0000);
      conclude();
   end
endmodule : testbench
